/* File: relay_function_blocks.sv */
// four-output relay controller driven by configurable function blocks
// Operation
// - eight input lines, four relay outputs, all driven by built-in blocks
// - each output owned by one block of eight selectable types
// - each pass evaluates output 0 first, then 1, 2, and 3 last
// - defaults: on-delay, count-up, weekday-time, year-window for outputs 0..3
// - count-up increments only on a rising edge of its count input
// - count-up output energizes once count reaches preset
// - count-up reset input clears count and de-energizes the output
// - on-delay starts its elapsed timer on a rising trigger edge
// - on-delay output energizes when elapsed time equals preset time
// - timers select millisecond or second resolution for preset time
// - year-window output on while clock lies within year on/off range
// - weekday-time output on while clock lies within day on/off range
// - on/off-delay: on-delay while true, then off-delay after false
// - window blocks hold four channels; any matching channel asserts output
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module relay_function_blocks #(
  parameter int MS_CYCLES = relay_pkg::MS_CYCLES
) (
  // clock and reset
  input  logic                           clk,
  input  logic                           arst_n,
  // register port
  input  relay_pkg::bus_req_s            bus_req,
  output logic [31:0]                    rdata_q,
  // field inputs and real-time clock keys
  input  logic [relay_pkg::NUM_IN-1:0]   in_lines,
  input  logic [15:0]                    rtc_year_key,
  input  logic [15:0]                    rtc_day_key,
  // relay drivers
  output logic [relay_pkg::NUM_OUT-1:0]  relay_q
);

  localparam int MSW = $clog2(MS_CYCLES);

  typedef struct packed {
    logic                              run;
    relay_pkg::cfg_s [3:0]             cfg;
    relay_pkg::run_s [3:0]             run_st;
    relay_pkg::scan_state_e            scan;
    logic [1:0]                        slot;
    logic [1:0]                        ch;
    logic                              hit;
    logic [MSW-1:0]                    ms_cnt;
    logic                              ms_pend;
    logic [9:0]                        sec_cnt;
    logic                              sec_pend;
    logic                              pass_ms;
    logic                              pass_sec;
    logic [3:0]                        relay;
    logic [31:0]                       rdata;
  } state_s;

  state_s      st_q;
  state_s      st_d;
  logic [31:0] chan_word;
  logic        chan_we;

  // one function block step; all timing uses the tick latched for this pass
  function automatic relay_pkg::run_s eval_slot(input relay_pkg::cfg_s c,
                                                input relay_pkg::run_s r,
                                                input logic [7:0] in,
                                                input logic hit,
                                                input logic tms,
                                                input logic tsec);
    relay_pkg::run_s n;
    logic x;
    logic rs;
    logic rise;
    logic fall;
    logic t;
    n    = r;
    x    = in[c.in_sel];
    rs   = in[c.rst_sel];
    rise = x & ~r.prev_in;
    fall = ~x & r.prev_in;
    t    = c.res_sec ? tsec : tms;
    n.prev_in = x;
    case (c.fb_type)
      relay_pkg::FB_ON_DELAY: begin
        if (!x) begin
          n.running      = 1'b0;
          n.elapsed_time = 16'h0000;
        end else if (rise) begin
          n.running      = 1'b1;
          n.elapsed_time = 16'h0000;
        end else if (r.running && t && r.elapsed_time != c.preset) begin
          n.elapsed_time = r.elapsed_time + 16'h0001;
        end
        n.out = x & n.running & (n.elapsed_time == c.preset);
      end
      relay_pkg::FB_OFF_DELAY: begin
        if (x) begin
          n.running      = 1'b0;
          n.elapsed_time = 16'h0000;
        end else begin
          if (fall) begin
            n.running      = 1'b1;
            n.elapsed_time = 16'h0000;
          end else if (r.running && t) begin
            n.elapsed_time = r.elapsed_time + 16'h0001;
          end
          if (n.elapsed_time == c.preset) begin
            n.running = 1'b0;
          end
        end
        n.out = x | n.running;
      end
      relay_pkg::FB_ON_OFF_DELAY: begin
        if (x) begin
          if (rise) begin
            n.running      = 1'b1;
            n.elapsed_time = 16'h0000;
          end else if (r.running && t && r.elapsed_time != c.preset) begin
            n.elapsed_time = r.elapsed_time + 16'h0001;
          end
          n.out = n.running & (n.elapsed_time == c.preset);
        end else begin
          // off phase only follows an energized on phase
          if (fall) begin
            n.running      = r.out;
            n.elapsed_time = 16'h0000;
          end else if (r.running && t) begin
            n.elapsed_time = r.elapsed_time + 16'h0001;
          end
          if (n.elapsed_time == c.preset) begin
            n.running = 1'b0;
          end
          n.out = n.running;
        end
      end
      relay_pkg::FB_PULSE: begin
        // retrigger is ignored while a pulse is running
        if (rise && !r.running) begin
          n.running      = 1'b1;
          n.elapsed_time = 16'h0000;
        end else if (r.running && t) begin
          n.elapsed_time = r.elapsed_time + 16'h0001;
        end
        if (n.elapsed_time == c.preset) begin
          n.running = 1'b0;
        end
        n.out = n.running;
      end
      relay_pkg::FB_COUNT_UP: begin
        if (rs) begin
          n.current_count = 16'h0000;
        end else if (rise && r.current_count != relay_pkg::COUNT_MAX) begin
          n.current_count = r.current_count + 16'h0001;
        end
        n.out = ~rs & (n.current_count >= c.preset);
      end
      relay_pkg::FB_COUNT_DOWN: begin
        if (rs) begin
          n.current_count = c.preset;
        end else if (rise && r.current_count != 16'h0000) begin
          n.current_count = r.current_count - 16'h0001;
        end
        n.out = ~rs & (n.current_count == 16'h0000);
      end
      relay_pkg::FB_YEAR_WINDOW: begin
        n.out = x & hit;
      end
      relay_pkg::FB_WEEKDAY_TIME: begin
        n.out = x & hit;
      end
      default: begin
        n.out = 1'b0;
      end
    endcase
    return n;
  endfunction

  // window settings, one word per output and channel
  assign chan_we = bus_req.wr && (bus_req.addr[7:4] == relay_pkg::ADDR_CHAN_BASE[7:4]);

  chan_mem #(
    .DW (32),
    .AW (4)
  ) u_chan_mem (
    .clk     (clk),
    .arst_n  (arst_n),
    .we      (chan_we),
    .waddr   (bus_req.addr[3:0]),
    .wdata   (bus_req.wdata),
    .raddr   ({st_q.slot, st_q.ch}),
    .rdata_q (chan_word)
  );

  // next state: time base, scan sequencer, register port
  always_comb begin
    relay_pkg::run_s nxt;
    logic [15:0]     key;
    logic            in_win;
    logic            ms_tick;
    logic            sec_tick;
    st_d     = st_q;
    nxt      = st_q.run_st[st_q.slot];
    key      = 16'h0000;
    in_win   = 1'b0;
    ms_tick  = 1'b0;
    sec_tick = 1'b0;

    // millisecond and second ticks, held pending until the next pass starts
    if (st_q.ms_cnt == MSW'(MS_CYCLES - 1)) begin
      st_d.ms_cnt = '0;
      ms_tick     = 1'b1;
    end else begin
      st_d.ms_cnt = st_q.ms_cnt + MSW'(1);
    end
    if (ms_tick) begin
      if (st_q.sec_cnt == 10'(relay_pkg::MS_PER_SEC - 1)) begin
        st_d.sec_cnt = 10'h000;
        sec_tick     = 1'b1;
      end else begin
        st_d.sec_cnt = st_q.sec_cnt + 10'h001;
      end
    end

    case (st_q.scan)
      relay_pkg::SCAN_READ: begin
        st_d.scan = relay_pkg::SCAN_ACC;
      end
      relay_pkg::SCAN_ACC: begin
        // channel word: on key in [15:0], off key in [31:16], off exclusive
        if (st_q.cfg[st_q.slot].fb_type == relay_pkg::FB_YEAR_WINDOW) begin
          key = rtc_year_key;
        end else begin
          key = rtc_day_key;
        end
        in_win   = (key >= chan_word[15:0]) && (key < chan_word[31:16]);
        st_d.hit = st_q.hit | in_win;
        if (st_q.ch == 2'h3) begin
          st_d.scan = relay_pkg::SCAN_EVAL;
        end else begin
          st_d.ch   = st_q.ch + 2'h1;
          st_d.scan = relay_pkg::SCAN_READ;
        end
      end
      relay_pkg::SCAN_EVAL: begin
        nxt = eval_slot(st_q.cfg[st_q.slot], st_q.run_st[st_q.slot], in_lines,
                        st_q.hit, st_q.pass_ms, st_q.pass_sec);
        if (st_q.run) begin
          st_d.run_st[st_q.slot] = nxt;
          st_d.relay[st_q.slot]  = nxt.out;
        end else begin
          st_d.run_st[st_q.slot] = '0;
          st_d.relay[st_q.slot]  = 1'b0;
        end
        st_d.slot = st_q.slot + 2'h1;
        st_d.ch   = 2'h0;
        st_d.hit  = 1'b0;
        st_d.scan = relay_pkg::SCAN_READ;
        if (st_q.slot == 2'h3) begin
          // pass boundary: take pending ticks for the whole next pass
          st_d.pass_ms  = st_q.ms_pend;
          st_d.pass_sec = st_q.sec_pend;
          st_d.ms_pend  = 1'b0;
          st_d.sec_pend = 1'b0;
        end
      end
      default: begin
        st_d.scan = relay_pkg::SCAN_READ;
      end
    endcase

    // a tick in the consuming cycle stays pending
    if (ms_tick) begin
      st_d.ms_pend = 1'b1;
    end
    if (sec_tick) begin
      st_d.sec_pend = 1'b1;
    end

    // register writes; they follow the scan so software wins a collision
    if (bus_req.wr) begin
      if (bus_req.addr == relay_pkg::ADDR_CTRL) begin
        st_d.run = bus_req.wdata[relay_pkg::CTRL_RUN_BIT];
        if (bus_req.wdata[relay_pkg::CTRL_DEFAULTS_BIT]) begin
          st_d.cfg    = relay_pkg::CFG_DEFAULTS;
          st_d.run_st = '0;
        end
      end else if (bus_req.addr[7:2] == relay_pkg::ADDR_CFG_BASE[7:2]) begin
        st_d.cfg[bus_req.addr[1:0]] = bus_req.wdata[relay_pkg::CFG_WIDTH-1:0];
      end
    end

    // read data live for one cycle only; unmapped and channel words read zero
    st_d.rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      if (bus_req.addr == relay_pkg::ADDR_CTRL) begin
        st_d.rdata = {31'h0000_0000, st_q.run};
      end else if (bus_req.addr == relay_pkg::ADDR_STATUS) begin
        st_d.rdata = {20'h00000, st_q.relay, in_lines};
      end else if (bus_req.addr[7:2] == relay_pkg::ADDR_CFG_BASE[7:2]) begin
        st_d.rdata = {6'h00, st_q.cfg[bus_req.addr[1:0]]};
      end else if (bus_req.addr[7:2] == relay_pkg::ADDR_RUN_BASE[7:2]) begin
        st_d.rdata = {st_q.run_st[bus_req.addr[1:0]].elapsed_time,
                      st_q.run_st[bus_req.addr[1:0]].current_count};
      end
    end
  end

  // state register; configuration wakes up in the default block layout
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q     <= '0;
      st_q.run <= relay_pkg::CTRL_RUN_RESET;
      st_q.cfg <= relay_pkg::CFG_DEFAULTS;
    end else begin
      st_q <= st_d;
    end
  end

  assign relay_q = st_q.relay;
  assign rdata_q = st_q.rdata;

endmodule

/* File: relay_pkg.sv */
// shared constants, types and register map of the relay function block controller
package relay_pkg;

  // geometry
  localparam int NUM_IN  = 8;
  localparam int NUM_OUT = 4;
  localparam int NUM_CH  = 4;

  // function block types
  typedef enum logic [2:0] {
    FB_ON_DELAY     = 3'h0,
    FB_OFF_DELAY    = 3'h1,
    FB_YEAR_WINDOW  = 3'h2,
    FB_WEEKDAY_TIME = 3'h3,
    FB_COUNT_UP     = 3'h4,
    FB_COUNT_DOWN   = 3'h5,
    FB_ON_OFF_DELAY = 3'h6,
    FB_PULSE        = 3'h7
  } fb_type_e;

  // scan sequencer, gray along read -> accumulate -> evaluate
  typedef enum logic [1:0] {
    SCAN_READ = 2'h0,
    SCAN_ACC  = 2'h1,
    SCAN_EVAL = 2'h3
  } scan_state_e;

  // per-output configuration, bits [25:0] of a cfg register
  typedef struct packed {
    logic [15:0] preset;
    logic        res_sec;
    logic [2:0]  rst_sel;
    logic [2:0]  in_sel;
    fb_type_e    fb_type;
  } cfg_s;

  // per-output run state
  typedef struct packed {
    logic [15:0] current_count;
    logic [15:0] elapsed_time;
    logic        running;
    logic        prev_in;
    logic        out;
  } run_s;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  // register word indices
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h01;
  localparam logic [7:0] ADDR_CFG_BASE  = 8'h04;
  localparam logic [7:0] ADDR_RUN_BASE  = 8'h08;
  localparam logic [7:0] ADDR_CHAN_BASE = 8'h20;

  // field positions
  localparam int CTRL_RUN_BIT      = 0;
  localparam int CTRL_DEFAULTS_BIT = 1;
  localparam int CFG_WIDTH         = 26;

  // reset values and count-up saturation limit
  localparam logic        CTRL_RUN_RESET = 1'b0;
  localparam logic [15:0] PRESET_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;
  localparam cfg_s [3:0] CFG_DEFAULTS = {
    cfg_s'{PRESET_RESET, 1'b0, 3'h0, 3'h0, FB_YEAR_WINDOW},
    cfg_s'{PRESET_RESET, 1'b0, 3'h0, 3'h0, FB_WEEKDAY_TIME},
    cfg_s'{PRESET_RESET, 1'b0, 3'h0, 3'h0, FB_COUNT_UP},
    cfg_s'{PRESET_RESET, 1'b0, 3'h0, 3'h0, FB_ON_DELAY}
  };

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_PER_SEC    = 1000;

endpackage

/* File: chan_mem.sv */
// window channel memory with registered read data
`timescale 1ns/1ps
module chan_mem #(
  parameter int DW = 32,
  parameter int AW = 4
) (
  // clock and reset
  input  logic          clk,
  input  logic          arst_n,
  // write port
  input  logic          we,
  input  logic [AW-1:0] waddr,
  input  logic [DW-1:0] wdata,
  // read port
  input  logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rdata;
  } mem_state_s;

  mem_state_s st_q;
  mem_state_s st_d;

  // a read of the word being written returns the old contents
  always_comb begin
    st_d = st_q;
    if (we) begin
      st_d.mem[waddr] = wdata;
    end
    st_d.rdata = st_q.mem[raddr];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_q = st_q.rdata;

endmodule

/* File: relay_function_blocks_assertions.sv */
// port checker for the relay function block controller
`timescale 1ns/1ps
module relay_function_blocks_assertions #(
  parameter int MS_CYCLES = relay_pkg::MS_CYCLES
) (
  // clock and reset
  input logic                clk,
  input logic                arst_n,
  // register port
  input relay_pkg::bus_req_s bus_req,
  input logic [31:0]         rdata_q,
  // field side
  input logic [7:0]          in_lines,
  input logic [15:0]         rtc_year_key,
  input logic [15:0]         rtc_day_key,
  input logic [3:0]          relay_q
);
  logic       run_q;
  logic [7:0] calm_q;

  // mirror the run bit; count cycles since the last control write, since a
  // run change only settles after a whole scan pass of 36 clocks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q  <= 1'b0;
      calm_q <= 8'h00;
    end else if (bus_req.wr && bus_req.addr == relay_pkg::ADDR_CTRL) begin
      run_q  <= bus_req.wdata[relay_pkg::CTRL_RUN_BIT];
      calm_q <= 8'h00;
    end else if (calm_q != 8'hff) begin
      calm_q <= calm_q + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_rdata_idle;
    !$past(bus_req.rd) |-> rdata_q == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data seen without a read");

  property p_ctrl_read;
    $past(bus_req.rd) && $past(bus_req.addr) == relay_pkg::ADDR_CTRL
      |-> rdata_q == {31'h0, $past(run_q)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read does not show the run bit");

  property p_status_read;
    $past(bus_req.rd) && $past(bus_req.addr) == relay_pkg::ADDR_STATUS
      |-> rdata_q == {20'h0, $past(relay_q), $past(in_lines)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not show lines and relays");

  property p_hole_read;
    $past(bus_req.rd) && ($past(bus_req.addr) inside {8'h02, 8'h03}
      || $past(bus_req.addr) >= 8'h0c) |-> rdata_q == 32'h0;
  endproperty
  a_hole_read: assert property (p_hole_read)
    else $error("unmapped or channel read returned data");

  property p_cfg_read;
    $past(bus_req.rd) && $past(bus_req.addr) inside {[8'h04:8'h07]} |-> rdata_q[31:26] == 6'h0;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("configuration read has upper bits set");

  property p_prog_off;
    !run_q && calm_q >= 8'd40 |-> relay_q == 4'h0;
  endproperty
  a_prog_off: assert property (p_prog_off)
    else $error("relay energized outside run mode");

  property p_one_output_per_cycle;
    run_q && calm_q >= 8'd40 |-> $onehot0(relay_q ^ $past(relay_q));
  endproperty
  a_one_output_per_cycle: assert property (p_one_output_per_cycle)
    else $error("two relays changed in one cycle");

  property p_relay_stands;
    run_q && calm_q >= 8'd40 && $changed(relay_q) |=> $stable(relay_q) [*8];
  endproperty
  a_relay_stands: assert property (p_relay_stands)
    else $error("relays changed twice within one block slot");
endmodule

bind relay_function_blocks relay_function_blocks_assertions #(
  .MS_CYCLES(MS_CYCLES)
) u_chk (
  .clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata_q(rdata_q),
  .in_lines(in_lines), .rtc_year_key(rtc_year_key), .rtc_day_key(rtc_day_key),
  .relay_q(relay_q)
);

/* File: relay_field_model.sv */
// field side model: push buttons on the eight input lines
`timescale 1ns/1ps
module relay_field_model (
  // clock
  input  logic       clk,
  // field wiring
  output logic [7:0] in_lines
);
  initial in_lines = 8'h00;

  // press and release; each level outlasts a 36 clock scan so edges are seen
  task automatic pulse(input int line, input int hold);
    @(posedge clk);
    in_lines[line] <= 1'b1;
    repeat (hold) @(posedge clk);
    in_lines[line] <= 1'b0;
    repeat (hold) @(posedge clk);
  endtask

  // set all lines at once
  task automatic set(input logic [7:0] v);
    @(posedge clk);
    in_lines <= v;
  endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the relay function block controller
`timescale 1ns/1ps
module tb_top;
  localparam int MSC = 64;
  logic                clk;
  logic                arst_n;
  relay_pkg::bus_req_s bus_req;
  logic [31:0]         rdata_q;
  logic [7:0]          in_lines;
  logic [15:0]         rtc_year_key;
  logic [15:0]         rtc_day_key;
  logic [3:0]          relay_q;
  int                  bad_count;
  int                  comparisons;
  int                  seed;
  int                  cycles;
  logic [31:0]         rd;
  logic [31:0]         r;
  logic [15:0]         on_k [4];
  logic [15:0]         off_k [4];

  relay_function_blocks #(.MS_CYCLES(MSC)) DUT (
    .clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata_q(rdata_q),
    .in_lines(in_lines), .rtc_year_key(rtc_year_key), .rtc_day_key(rtc_day_key),
    .relay_q(relay_q)
  );
  relay_field_model field (.clk(clk), .in_lines(in_lines));

  // scan clock, 100 ns period
  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_word(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata_q;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // wait for relay 0 to reach a level, bounded by four millisecond ticks
  task automatic wait_r0(input logic v);
    for (int n = 0; n < 4 * MSC && relay_q[0] !== v; n++) settle(1);
  endtask

  function automatic logic [31:0] cfg(input relay_pkg::fb_type_e t, input logic [2:0] i,
                                      input logic [2:0] s, input logic [15:0] p);
    cfg = {6'h0, p, 1'b0, s, i, t};
  endfunction

  // a window block hits when any channel has on <= key < off
  function automatic logic win(input logic [15:0] k);
    win = 1'b0;
    for (int c = 0; c < 4; c++)
      if (on_k[c] <= k && k < off_k[c]) win = 1'b1;
  endfunction

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    seed = 32'hb12a;
    arst_n = 1'b0;
    bus_req = '0;
    rtc_year_key = 16'h0000;
    rtc_day_key = 16'h0000;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd_word(relay_pkg::ADDR_CTRL, rd);
    check("ctrl", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      rd_word(relay_pkg::ADDR_CFG_BASE + 8'(i), rd);
      check("cfg default", {6'h0, relay_pkg::CFG_DEFAULTS[i]}, rd);
    end
    rd_word(8'h10, rd);
    check("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      field.set(r[7:0]);
      rd_word(relay_pkg::ADDR_STATUS, rd);
      check("status", {24'h0, r[7:0]}, rd);
    end
    field.set(8'h00);
    // on-delay of 3 ms on output 0, started by line 1
    wr(relay_pkg::ADDR_CFG_BASE, cfg(relay_pkg::FB_ON_DELAY, 3'h1, 3'h0, 16'h0003));
    wr(relay_pkg::ADDR_CTRL, 32'h1);
    settle(40);
    field.set(8'h02);
    settle(2 * MSC - 40);
    check("on delay early", 32'h0, {31'h0, relay_q[0]});
    for (int n = 0; n < 4 * MSC && relay_q[0] !== 1'b1; n++) settle(1);
    check("on delay done", 32'h1, {31'h0, relay_q[0]});
    // off-delay of 2 ms: relay holds after line 1 drops, then releases
    wr(relay_pkg::ADDR_CFG_BASE, cfg(relay_pkg::FB_OFF_DELAY, 3'h1, 3'h0, 16'h0002));
    field.set(8'h00);
    settle(50);
    check("off delay hold", 32'h1, {31'h0, relay_q[0]});
    wait_r0(1'b0);
    check("off delay done", 32'h0, {31'h0, relay_q[0]});
    // pulse of 2 ms started by a rising edge, ends while the line stays high
    wr(relay_pkg::ADDR_CFG_BASE, cfg(relay_pkg::FB_PULSE, 3'h1, 3'h0, 16'h0002));
    field.set(8'h02);
    settle(40);
    check("pulse on", 32'h1, {31'h0, relay_q[0]});
    wait_r0(1'b0);
    check("pulse off", 32'h0, {31'h0, relay_q[0]});
    // on/off-delay of 2 ms each way
    wr(relay_pkg::ADDR_CFG_BASE, cfg(relay_pkg::FB_ON_OFF_DELAY, 3'h1, 3'h0, 16'h0002));
    field.set(8'h00);
    settle(40);
    field.set(8'h02);
    settle(40);
    check("onoff early", 32'h0, {31'h0, relay_q[0]});
    wait_r0(1'b1);
    check("onoff on", 32'h1, {31'h0, relay_q[0]});
    field.set(8'h00);
    settle(40);
    check("onoff hold", 32'h1, {31'h0, relay_q[0]});
    wait_r0(1'b0);
    check("onoff off", 32'h0, {31'h0, relay_q[0]});
    // seconds resolution: a preset of 1 must not fire within a few milliseconds
    wr(relay_pkg::ADDR_CFG_BASE, cfg(relay_pkg::FB_ON_DELAY, 3'h1, 3'h0, 16'h0001) | 32'h200);
    field.set(8'h02);
    settle(6 * MSC);
    check("sec resolution", 32'h0, {31'h0, relay_q[0]});
    // count-up on output 1: count line 2, reset line 3, preset 3
    wr(relay_pkg::ADDR_CFG_BASE + 8'h1, cfg(relay_pkg::FB_COUNT_UP, 3'h2, 3'h3, 16'h0003));
    for (int n = 1; n <= 3; n++) begin
      field.pulse(2, 40);
      rd_word(relay_pkg::ADDR_RUN_BASE + 8'h1, rd);
      check("up count", 32'(n), {16'h0, rd[15:0]});
      check("up relay", {31'h0, n == 3}, {31'h0, relay_q[1]});
    end
    field.pulse(3, 40);
    rd_word(relay_pkg::ADDR_RUN_BASE + 8'h1, rd);
    check("up cleared", 32'h0, {16'h0, rd[15:0]});
    check("up relay off", 32'h0, {31'h0, relay_q[1]});
    // count-down with preset 2: reset reloads, relay on at zero
    wr(relay_pkg::ADDR_CFG_BASE + 8'h1, cfg(relay_pkg::FB_COUNT_DOWN, 3'h2, 3'h3, 16'h0002));
    field.pulse(3, 40);
    check("down reloaded", 32'h0, {31'h0, relay_q[1]});
    field.pulse(2, 40);
    field.pulse(2, 40);
    rd_word(relay_pkg::ADDR_RUN_BASE + 8'h1, rd);
    check("down count", 32'h0, {16'h0, rd[15:0]});
    check("down relay", 32'h1, {31'h0, relay_q[1]});
    // window blocks on outputs 2 and 3, enabled by line 4, same four channels
    wr(relay_pkg::ADDR_CFG_BASE + 8'h2, cfg(relay_pkg::FB_WEEKDAY_TIME, 3'h4, 3'h0, 16'h0));
    wr(relay_pkg::ADDR_CFG_BASE + 8'h3, cfg(relay_pkg::FB_YEAR_WINDOW, 3'h4, 3'h0, 16'h0));
    for (int c = 0; c < 4; c++) begin
      r = $random(seed);
      on_k[c] = {8'h00, r[7:0]};
      off_k[c] = on_k[c] + {8'h00, r[11:8], 4'h0};
      wr(relay_pkg::ADDR_CHAN_BASE + 8'h8 + 8'(c), {off_k[c], on_k[c]});
      wr(relay_pkg::ADDR_CHAN_BASE + 8'hc + 8'(c), {off_k[c], on_k[c]});
    end
    field.set(8'h10);
    for (int k = 0; k < 10; k++) begin
      r = $random(seed);
      @(posedge clk);
      rtc_day_key <= (k == 0) ? on_k[0] : (k == 1) ? off_k[0] : {7'h00, r[8:0]};
      rtc_year_key <= (k == 2) ? on_k[1] : {7'h00, r[24:16]};
      // a key change can split one slot's channel sweep, so allow two passes
      settle(80);
      check("weekday", {31'h0, win(rtc_day_key)}, {31'h0, relay_q[2]});
      check("year", {31'h0, win(rtc_year_key)}, {31'h0, relay_q[3]});
    end
    // program mode drops every relay within a pass
    wr(relay_pkg::ADDR_CTRL, 32'h0);
    settle(40);
    check("prog relays", 32'h0, {28'h0, relay_q});
    // reset in mid-run restores defaults
    wr(relay_pkg::ADDR_CTRL, 32'h1);
    settle(5);
    arst_n <= 1'b0;
    settle(2);
    arst_n <= 1'b1;
    rd_word(relay_pkg::ADDR_CFG_BASE + 8'h1, rd);
    check("cfg after reset", {6'h0, relay_pkg::CFG_DEFAULTS[1]}, rd);
    summarize();
  end
endmodule
